// file: supervisor_pkg.sv
// Constants, types and register map for the supply supervisor and watchdog.
// Assumes one 40 MHz clock and a synchronous active-high reset everywhere.
// What this block does
// - Reset low on low line or VCC below battery
// - Hold reset 50 ms after low line clears
// - Watchdog timeout gives a 50 ms reset pulse
// - Stuck high or low input: pulse, fault low
// - Mid or floating watchdog input disables watchdog
// - Every watchdog input transition restarts the timeout
// - Power-fail warning low while sense below threshold
// - VCC below battery forces power-fail warning low
// - Gated chip select low only if enabled, line good
// - Backup-active high while running from battery
// - Supply-low output follows low line without delay
// - Active-high reset is inverse of active-low reset
// - Select high: internal timebase; low: external timebase
// - Select high: timebase input picks fast/slow timeout
// - Fault clears on transition while reset high; stays high at mid
// - Fault forced high while supply-low is low
// - Unserviced watchdog repeats reset pulse every period
// - Fault clears on transition while reset high, or at mid level, low line or software disable
`default_nettype none

package supervisor_pkg;

   // Clock rate
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;

   // Times in their own units
   localparam int unsigned RESET_DELAY_MS = 50;    // Reset pulse and recovery delay
   localparam int unsigned WD_SLOW_MS     = 1600;  // Default watchdog timeout
   localparam int unsigned WD_FAST_MS     = 100;   // Short watchdog timeout

   // Derived cycle counts
   localparam int unsigned RESET_DELAY_CYC = RESET_DELAY_MS * CYC_PER_MS;
   localparam int unsigned WD_SLOW_CYC     = WD_SLOW_MS * CYC_PER_MS;
   localparam int unsigned WD_FAST_CYC     = WD_FAST_MS * CYC_PER_MS;

   // External timebase edge counts
   localparam int unsigned EXT_RESET_EDGES = 1024;
   localparam int unsigned EXT_WD_EDGES    = 4096;

   // Counter width
   localparam int unsigned CNT_W = 32;

   // Register map, byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;

   // Control field positions and reset value
   localparam int unsigned CTRL_WD_OFF_BIT = 0;
   localparam logic        CTRL_RESET_VAL  = 1'b0;

   // Pin inputs from outside the clock domain
   typedef struct packed {
      logic low_line_in;        // High: low-line input above threshold
      logic vcc_below_backup;   // High: VCC below backup battery level
      logic power_fail_sense;   // High: monitored supply above threshold
      logic chip_select_in_n;   // Chip-select request, active low
      logic wd_high_detect;     // Watchdog input at high level
      logic wd_low_detect;      // Watchdog input at low level
      logic timebase_select;    // High: internal timebase
      logic timebase_input;     // External timebase or speed pick
   } pins_in_t;

   // Pin outputs
   typedef struct packed {
      logic reset_n;              // Active-low reset
      logic reset;                // Active-high reset
      logic supply_low_n;         // Low-line indication
      logic watchdog_fault_n;     // Watchdog fault, active low
      logic power_fail_warn_n;    // Power-fail warning, active low
      logic backup_supply_active; // Running from battery
      logic chip_select_gated_n;  // Gated chip select
   } pins_out_t;

   // Watchdog input level
   typedef enum logic [1:0] {WD_MID, WD_LOW, WD_HIGH} wd_level_t;

   // Supervisor states
   typedef enum logic [1:0] {ST_HOLD, ST_DELAY, ST_RUN, ST_PULSE} sup_state_t;

endpackage : supervisor_pkg

`default_nettype wire

// file: pin_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pin levels.
// Assumes each bit is an independent level; no multi-bit coherence.
`default_nettype none

module pin_sync
#(
   parameter int unsigned W = 8
)
(
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   ////////////////////////////////////////////////////////////////////////////
   logic [W-1:0] meta_reg;   // First stage, read only by q
   logic [W-1:0] meta_next;  // Next first stage
   logic [W-1:0] q_next;     // Next second stage

   // Next values
   always_comb
   begin
      meta_next = d;
      q_next    = meta_reg;
   end

   // Two flops in a row
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         meta_reg <= '0;
         q        <= '0;
      end
      else
      begin
         meta_reg <= meta_next;
         q        <= q_next;
      end
   end

endmodule : pin_sync

`default_nettype wire

// file: tick_timer.sv
// Tick counter with clear and a one-cycle expiry pulse.
// Assumes limit is at least one and stable while counting.
`default_nettype none

module tick_timer
   import supervisor_pkg::*;
#(
   parameter int unsigned CW = CNT_W
)
(
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire logic          clear,
   input  wire logic          tick,
   input  wire logic [CW-1:0] limit,
   output var  logic          expired
);

   ////////////////////////////////////////////////////////////////////////////
   logic [CW-1:0] count_reg;    // Ticks seen
   logic [CW-1:0] count_next;   // Next count
   logic          expired_next; // Next expiry pulse

   // Count ticks, wrap at the limit
   always_comb
   begin
      count_next   = count_reg;
      expired_next = 1'b0;
      if (clear)
      begin
         count_next = '0;
      end
      else if (tick)
      begin
         if (count_reg >= limit - CW'(1))
         begin
            count_next   = '0;
            expired_next = 1'b1;
         end
         else
         begin
            count_next = count_reg + CW'(1);
         end
      end
   end

   // Register
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         count_reg <= '0;
         expired   <= 1'b0;
      end
      else
      begin
         count_reg <= count_next;
         expired   <= expired_next;
      end
   end

endmodule : tick_timer

`default_nettype wire

// file: supply_supervisor_reset_watchdog.sv
// Supply supervisor: reset generation, watchdog, power-fail, chip-select gate.
// Assumes asynchronous pins are levels and a classic Wishbone master on clk.
`default_nettype none

module supply_supervisor_reset_watchdog
   import supervisor_pkg::*;
#(
   parameter int unsigned RESET_CYCLES    = RESET_DELAY_CYC,
   parameter int unsigned WD_SLOW_CYCLES  = WD_SLOW_CYC,
   parameter int unsigned WD_FAST_CYCLES  = WD_FAST_CYC,
   parameter int unsigned EXT_RESET_TICKS = EXT_RESET_EDGES,
   parameter int unsigned EXT_WD_TICKS    = EXT_WD_EDGES
)
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire pins_in_t    pins_in,
   output var  pins_out_t   pins_out,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Parameter checks
   generate
      // Shorter delays would release reset inside the guarded hold window
      if (RESET_CYCLES < 3 || EXT_RESET_TICKS < 2 || EXT_WD_TICKS < 1)
      begin : g_bad_delay
         $error("Delay counts too small");
      end
      if (WD_FAST_CYCLES <= RESET_CYCLES || WD_SLOW_CYCLES <= RESET_CYCLES)
      begin : g_bad_timeout
         $error("Watchdog timeout must exceed reset pulse");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Synchronised pins
   logic [$bits(pins_in_t)-1:0] sync_bits;  // Synchroniser output
   pins_in_t                    s;          // Synchronised pin bundle

   pin_sync #(
      .W ($bits(pins_in_t))
   ) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .d       (pins_in),
      .q       (sync_bits)
   );

   assign s = pins_in_t'(sync_bits);

   ////////////////////////////////////////////////////////////////////////////
   // Decoded conditions
   logic      low_cond;     // Reset-forcing supply condition
   wd_level_t wd_level;     // Decoded watchdog level
   logic      ctrl_wd_off;  // Software watchdog disable
   logic      wd_disabled;  // Watchdog out of service

   // Supply and watchdog level decode
   always_comb
   begin
      low_cond = !s.low_line_in || s.vcc_below_backup;
      if (s.wd_high_detect && !s.wd_low_detect)
      begin
         wd_level = WD_HIGH;
      end
      else if (s.wd_low_detect && !s.wd_high_detect)
      begin
         wd_level = WD_LOW;
      end
      else
      begin
         wd_level = WD_MID;
      end
      wd_disabled = (wd_level == WD_MID) || ctrl_wd_off;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timebase and watchdog edge tracking
   logic      tb_prev_reg;    // Last timebase level
   logic      tb_prev_next;   // Next timebase level
   wd_level_t wd_prev_reg;    // Last watchdog level
   wd_level_t wd_prev_next;   // Next watchdog level
   logic      tick;           // Counting tick
   logic      wd_edge;        // Watchdog input transition
   logic [CNT_W-1:0] rst_limit; // Reset delay in ticks
   logic [CNT_W-1:0] wd_limit;  // Watchdog timeout in ticks

   // Tick source and limits
   always_comb
   begin
      tb_prev_next = s.timebase_input;
      wd_prev_next = wd_level;
      wd_edge      = (wd_level != wd_prev_reg) && (wd_level != WD_MID);
      if (s.timebase_select)
      begin
         tick      = 1'b1;
         rst_limit = CNT_W'(RESET_CYCLES);
         // High level picks the slow timeout
         wd_limit  = s.timebase_input ? CNT_W'(WD_SLOW_CYCLES)
                                      : CNT_W'(WD_FAST_CYCLES);
      end
      else
      begin
         tick      = s.timebase_input && !tb_prev_reg;
         rst_limit = CNT_W'(EXT_RESET_TICKS);
         wd_limit  = CNT_W'(EXT_WD_TICKS);
      end
   end

   // Edge history
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         tb_prev_reg <= 1'b0;
         wd_prev_reg <= WD_MID;
      end
      else
      begin
         tb_prev_reg <= tb_prev_next;
         wd_prev_reg <= wd_prev_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timers
   sup_state_t state_reg;   // Supervisor state
   sup_state_t state_next;  // Next state
   logic       rst_clear;   // Reset timer clear
   logic       rst_done;    // Reset delay elapsed
   logic       wd_clear;    // Watchdog timer clear
   logic       wd_expired;  // Watchdog timeout elapsed

   // Reset timer runs only in delay or pulse
   assign rst_clear = (state_reg == ST_HOLD) || (state_reg == ST_RUN);
   // Watchdog restarts on edges, while disabled and before reset release
   assign wd_clear  = wd_disabled || wd_edge || low_cond ||
                      (state_reg == ST_HOLD) || (state_reg == ST_DELAY);

   tick_timer #(
      .CW (CNT_W)
   ) u_rst_timer (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clear   (rst_clear),
      .tick    (tick),
      .limit   (rst_limit),
      .expired (rst_done)
   );

   tick_timer #(
      .CW (CNT_W)
   ) u_wd_timer (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clear   (wd_clear),
      .tick    (tick),
      .limit   (wd_limit),
      .expired (wd_expired)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Supervisor state machine
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_HOLD:
         begin
            // Wait for the supply to recover
            if (!low_cond)
            begin
               state_next = ST_DELAY;
            end
         end
         ST_DELAY:
         begin
            // Low line again restarts the delay from zero
            if (low_cond)
            begin
               state_next = ST_HOLD;
            end
            else if (rst_done)
            begin
               state_next = ST_RUN;
            end
         end
         ST_RUN:
         begin
            if (low_cond)
            begin
               state_next = ST_HOLD;
            end
            else if (wd_expired)
            begin
               state_next = ST_PULSE;
            end
         end
         ST_PULSE:
         begin
            if (low_cond)
            begin
               state_next = ST_HOLD;
            end
            else if (rst_done)
            begin
               state_next = ST_RUN;
            end
         end
         default:
         begin
            state_next = ST_HOLD;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_reg <= ST_HOLD;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output pins
   pins_out_t out_next;  // Next pin values

   always_comb
   begin
      out_next                      = pins_out;
      out_next.reset_n              = (state_next == ST_RUN);
      out_next.reset                = !(state_next == ST_RUN);
      out_next.supply_low_n         = s.low_line_in;
      out_next.power_fail_warn_n    = s.power_fail_sense &&
                                      !s.vcc_below_backup;
      out_next.backup_supply_active = s.vcc_below_backup;
      out_next.chip_select_gated_n  = !(!s.chip_select_in_n && s.low_line_in &&
                                        !s.vcc_below_backup);
      // Fault output priority: forced high, then timeout, then service
      if (!s.low_line_in || wd_disabled)
      begin
         out_next.watchdog_fault_n = 1'b1;
      end
      else if (wd_expired && state_reg == ST_RUN)
      begin
         out_next.watchdog_fault_n = 1'b0;
      end
      else if (wd_edge && pins_out.reset_n)
      begin
         out_next.watchdog_fault_n = 1'b1;
      end
   end

   // Output register
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pins_out <= '{reset_n: 1'b0, reset: 1'b1, supply_low_n: 1'b0,
                       watchdog_fault_n: 1'b1, power_fail_warn_n: 1'b0,
                       backup_supply_active: 1'b0, chip_select_gated_n: 1'b1};
      end
      else
      begin
         pins_out <= out_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone register slave
   logic        ctrl_reg;   // Watchdog software disable
   logic        ctrl_next;  // Next control
   logic        ack_next;   // Next acknowledge
   logic [31:0] dat_next;   // Next read data

   assign ctrl_wd_off = ctrl_reg;

   // Decode, one wait state, unmapped reads give zero
   always_comb
   begin
      ctrl_next = ctrl_reg;
      ack_next  = wb_cyc_i && wb_stb_i && !wb_ack_o;
      dat_next  = '0;
      if (ack_next)
      begin
         case (wb_adr_i)
            CTRL_OFS:
            begin
               dat_next[CTRL_WD_OFF_BIT] = ctrl_reg;
               if (wb_we_i && wb_sel_i[0])
               begin
                  ctrl_next = wb_dat_i[CTRL_WD_OFF_BIT];
               end
            end
            STATUS_OFS:
            begin
               dat_next = {20'h00000, state_reg, wd_level, 1'b0, pins_out};
            end
            default:
            begin
               dat_next = '0;
            end
         endcase
      end
   end

   // Bus registers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ctrl_reg <= CTRL_RESET_VAL;
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         wb_ack_o <= ack_next;
         wb_dat_o <= dat_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_low_forces_reset: assert property (@(posedge clk) disable iff (sys_rst)
      low_cond |=> !pins_out.reset_n)
      else $error("Reset not asserted on low supply");

   a_delay_holds_reset: assert property (@(posedge clk) disable iff (sys_rst)
      (state_reg == ST_HOLD && !low_cond) |=> !pins_out.reset_n [*4])
      else $error("Reset released without delay");

   a_reset_inverse: assert property (@(posedge clk) disable iff (sys_rst)
      pins_out.reset_n |-> !pins_out.reset ##1 (pins_out.reset == !pins_out.reset_n))
      else $error("Active-high reset not inverse");

   a_timeout_pulses: assert property (@(posedge clk) disable iff (sys_rst)
      (state_reg == ST_RUN && wd_expired && !low_cond && !wd_disabled)
         |=> (!pins_out.reset_n && !pins_out.watchdog_fault_n))
      else $error("Timeout gave no pulse and fault");

   a_mid_keeps_fault: assert property (@(posedge clk) disable iff (sys_rst)
      (wd_level == WD_MID) |=> pins_out.watchdog_fault_n)
      else $error("Fault low with watchdog disabled");

   a_lowline_fault_high: assert property (@(posedge clk) disable iff (sys_rst)
      !s.low_line_in |=> (pins_out.watchdog_fault_n && !pins_out.supply_low_n))
      else $error("Fault not forced high on low line");

   a_pfo_follows: assert property (@(posedge clk) disable iff (sys_rst)
      (!s.power_fail_sense || s.vcc_below_backup) |=> !pins_out.power_fail_warn_n)
      else $error("Power-fail warning not low");

   a_cs_gate: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(s.low_line_in) |-> pins_out.chip_select_gated_n)
      else $error("Chip select passed on low line");

   a_batt_follows: assert property (@(posedge clk) disable iff (sys_rst)
      s.vcc_below_backup |=> pins_out.backup_supply_active)
      else $error("Backup-active not set");

   a_edge_clears_wd: assert property (@(posedge clk) disable iff (sys_rst)
      (wd_edge && !wd_disabled) |=> ##1 !wd_expired)
      else $error("Watchdog expired right after transition");

endmodule : supply_supervisor_reset_watchdog

`default_nettype wire

// file: proc_model.sv
// Processor model on the far side: drives the three-level watchdog line.
// Assumes clk is the supervisor clock and rst_n the supervisor's reset output.
`default_nettype none

module proc_model
#(
   parameter int unsigned PER = 10
)
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic serve,
   input  wire logic mid,
   output var  logic wd_hi,
   output var  logic wd_lo
);
   timeunit 1ns;
   timeprecision 1ps;

   int unsigned cnt = 0;    // Cycles since last toggle
   logic        lvl = 1'b0; // Line level when driven

   // Software toggles only while running and out of reset
   always @(posedge clk)
   begin
      if (serve && rst_n)
      begin
         cnt <= (cnt + 1) % PER;
         if (cnt == 0)
            lvl <= ~lvl;
      end
   end

   // Floating line shows neither level
   assign wd_hi = !mid && lvl;
   assign wd_lo = !mid && !lvl;
endmodule : proc_model

`default_nettype wire

// file: tb_supply_supervisor_reset_watchdog.sv
// Self-checking bench for the supply supervisor and watchdog.
// Assumes shortened timing parameters and the processor model beside it.
`default_nettype none

module tb_supply_supervisor_reset_watchdog
   import supervisor_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int RC = 20;  // Reset delay cycles
   localparam int WS = 200; // Slow timeout
   localparam int WF = 100; // Fast timeout
   localparam int XW = 16;  // External watchdog ticks
   localparam int XR = 4;   // External reset ticks

   logic        clk, sys_rst;
   pins_in_t    pins_in;
   pins_out_t   pins_out;
   logic        cyc, stb, we, ack;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, rd;
   logic        serve, mid, ext_run, speed, wd_hi, wd_lo;
   logic        ll, vb, pf, cs;
   logic [3:0]  sup_pins;       // Supply-side pin levels
   logic        tsel;           // Timebase select pin
   logic [1:0]  wd_q = 2'h0;    // Registered watchdog detect pair
   logic        tb_q = 1'b1;    // Registered timebase input
   logic [2:0]  tcnt = 3'h0;
   int          error_cnt, cmp_count, n, w, pw;

   supply_supervisor_reset_watchdog #(.RESET_CYCLES(RC), .WD_SLOW_CYCLES(WS),
      .WD_FAST_CYCLES(WF), .EXT_RESET_TICKS(XR), .EXT_WD_TICKS(XW)) dut
   (
      .clk(clk), .sys_rst(sys_rst), .pins_in(pins_in), .pins_out(pins_out),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack)
   );

   proc_model #(.PER(10)) cpu
   (
      .clk(clk), .rst_n(pins_out.reset_n), .serve(serve), .mid(mid),
      .wd_hi(wd_hi), .wd_lo(wd_lo)
   );

   ////////////////////////////////////////
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Watchdog line from the model; external ticks or speed pick
   always @(posedge clk)
   begin
      tcnt <= tcnt + 3'h1;
      wd_q <= {wd_hi, wd_lo};
      tb_q <= ext_run ? tcnt[2] : speed;
   end

   // Single driver for the pin bundle
   assign pins_in = {sup_pins, wd_q, tsel, tb_q};

   ////////////////////////////////////////
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Verdict and end of run
   task automatic wrap_up;
      if (error_cnt == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   // Wait ran out
   task automatic hang;
      error_cnt++;
      $display("MISMATCH %0t wait ran out", $time);
      wrap_up();
   endtask : hang

   // One when v lies in lo..hi
   function automatic logic [31:0] rng(input int v, input int lo, input int hi);
      return {31'h0, v >= lo && v <= hi};
   endfunction : rng

   // Cycles until reset_n reaches lvl, in n
   task automatic wait_rst(input logic lvl, input int lim);
      n = 0;
      while (pins_out.reset_n !== lvl)
      begin
         @(posedge clk);
         n++;
         if (n > lim)
            hang();
      end
   endtask : wait_rst

   // No reset pulse for k cycles
   task automatic quiet(input int k);
      w = 1;
      repeat (k)
      begin
         @(posedge clk);
         if (pins_out.reset_n !== 1'b1)
            w = 0;
      end
      chk(w, 1);
   endtask : quiet

   // Supply-side pin levels
   task automatic drive;
      @(posedge clk);
      sup_pins <= {ll, vb, pf, cs};
   endtask : drive

   // One classic bus cycle; read data lands in rd
   task automatic bus(input logic wr, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= wr;
      adr  <= a;
      sel  <= s;
      wdat <= d;
      do
      begin
         @(posedge clk);
         k++;
         if (k > 20)
            hang();
      end
      while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus

   ////////////////////////////////////////
   // Main sequence
   initial
   begin
      error_cnt = 0;
      cmp_count = 0;
      sys_rst = 1'b1;
      {cyc, stb, we, adr, sel, wdat} = '0;
      {serve, mid, ext_run, speed} = 4'b1001;
      {ll, vb, pf, cs} = 4'b1011;
      {sup_pins, tsel} = 5'h17;
      void'($urandom(32'h7d4b));
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      wait_rst(1'b1, 60);
      chk(rng(n, RC, RC + 10), 1);
      // Random supply levels
      for (int i = 0; i < 24; i++)
      begin
         ll = ($urandom % 4) != 0;
         vb = ($urandom % 4) == 0;
         pf = 1'($urandom);
         cs = 1'($urandom);
         drive();
         repeat (4) @(posedge clk);
         chk(pins_out.supply_low_n, ll);
         chk(pins_out.power_fail_warn_n, pf & !vb);
         chk(pins_out.backup_supply_active, vb);
         chk(pins_out.chip_select_gated_n, !(!cs && ll && !vb));
         chk(pins_out.reset, !pins_out.reset_n);
         if (!ll || vb)
            chk(pins_out.reset_n, 1'b0);
         if (!ll)
            chk(pins_out.watchdog_fault_n, 1'b1);
      end
      {ll, vb, pf, cs} = 4'b1011;
      drive();
      wait_rst(1'b1, 60);
      // Low line comes back during the delay
      ll = 1'b0;
      drive();
      repeat (6) @(posedge clk);
      ll = 1'b1;
      drive();
      repeat (10) @(posedge clk);
      ll = 1'b0;
      drive();
      repeat (6) @(posedge clk);
      ll = 1'b1;
      drive();
      repeat (4) @(posedge clk);
      chk(pins_out.supply_low_n, 1'b1);
      chk(pins_out.reset_n, 1'b0);
      wait_rst(1'b1, 60);
      chk(rng(n + 4, RC, RC + 10), 1);
      // Slow watchdog left unserviced
      repeat (50) @(posedge clk);
      serve <= 1'b0;
      wait_rst(1'b0, 400);
      chk(rng(n, WS - 14, WS + 10), 1);
      repeat (4) @(posedge clk);
      chk(pins_out.watchdog_fault_n, 1'b0);
      wait_rst(1'b1, 100);
      pw = n + 4;
      chk(rng(pw, RC, RC + 4), 1);
      wait_rst(1'b0, 400);
      chk(rng(n + pw, WS - 3, WS + 4), 1);
      chk(pins_out.watchdog_fault_n, 1'b0);
      wait_rst(1'b1, 100);
      serve <= 1'b1;
      repeat (20) @(posedge clk);
      chk(pins_out.watchdog_fault_n, 1'b1);
      quiet(600);
      mid <= 1'b1;
      quiet(600);
      chk(pins_out.watchdog_fault_n, 1'b1);
      // Fast timeout picked by the timebase input
      speed <= 1'b0;
      mid <= 1'b0;
      repeat (30) @(posedge clk);
      serve <= 1'b0;
      wait_rst(1'b0, 300);
      chk(rng(n, WF - 14, WF + 10), 1);
      wait_rst(1'b1, 100);
      serve <= 1'b1;
      repeat (20) @(posedge clk);
      // Registers: software disable, status, unmapped, lane gate
      bus(1'b1, CTRL_OFS, 4'hf, 32'h1);
      bus(1'b0, CTRL_OFS, 4'hf, 32'h0);
      chk(rd, 32'h1);
      serve <= 1'b0;
      quiet(400);
      bus(1'b1, STATUS_OFS, 4'hf, 32'hffffffff);
      bus(1'b0, STATUS_OFS, 4'hf, 32'h0);
      chk(rd & 32'hcff, 32'h85d);
      bus(1'b0, 8'h08, 4'hf, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, CTRL_OFS, 4'h0, 32'h0);
      bus(1'b0, CTRL_OFS, 4'hf, 32'h0);
      chk(rd, 32'h1);
      // External timebase: no ticks, no expiry; then ticks, timeout after XW edges, pulse of XR
      tsel <= 1'b0;
      bus(1'b1, CTRL_OFS, 4'hf, 32'h0);
      quiet(400);
      ext_run <= 1'b1;
      wait_rst(1'b0, 400);
      chk(rng(n, XW * 8 - 20, XW * 8 + 20), 1);
      wait_rst(1'b1, 100);
      chk(rng(n, XR * 8 - 10, XR * 8 + 10), 1);
      wrap_up();
   end
endmodule : tb_supply_supervisor_reset_watchdog

`default_nettype wire
